// >>> rtl/wpbrk_top.sv
// Breakpoint / watchpoint comparator units with debug abort status
`timescale 1ns/1ps
`include "wpbrk_regs.svh"

module wpbrk_unit (
  input wire logic [31:0] addr_val,
  input wire logic [31:0] addr_mask,
  input wire logic [31:0] data_val,
  input wire logic [31:0] data_mask,
  input wire logic [8:0] ctl_val,
  input wire logic [7:0] ctl_mask,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_data,
  input wire logic [7:0] bus_ctl,
  input wire logic half_fetch,
  output logic hit
);
  wire [31:0] addr_ok;
  wire [31:0] data_ok;
  wire [7:0] ctl_ok;
  wire lo_ok;
  wire hi_ok;
  wire data_match;
  assign addr_ok = ~(addr_val ^ bus_addr) | addr_mask;
  assign data_ok = ~(data_val ^ bus_data) | data_mask;
  assign ctl_ok = ~(ctl_val[7:0] ^ bus_ctl) | ctl_mask;
  assign lo_ok = &data_ok[15:0];
  assign hi_ok = &data_ok[31:16];
  // Halfword fetch: valid half picked by address bit 1
  assign data_match = half_fetch ? (bus_addr[1] ? hi_ok : lo_ok) : (lo_ok & hi_ok);
  assign hit = (&addr_ok) & data_match & (&ctl_ok) & ctl_val[`WPBRK_CTL_ENABLE];
endmodule : wpbrk_unit

module wpbrk_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cfg_wr,
  input wire logic [`WPBRK_ADDR_W-1:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_data,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire wpbrk_pkg::wpbrk_size_t bus_size,
  input wire logic fetch_or_data_select,
  input wire logic privileged_access_select,
  input wire logic [1:0] external_watch_condition,
  input wire logic half_fetch,
  input wire logic debug_abort_taken,
  input wire logic external_abort,
  input wire logic coprocessor_write_instruction,
  input wire logic [31:0] coprocessor_wdata,
  output logic [31:0] coprocessor_rdata,
  output logic [1:0] unit_hit,
  output logic debug_break
);
  import wpbrk_pkg::*;
  logic [31:0] av_ff [2];
  logic [31:0] am_ff [2];
  logic [31:0] dv_ff [2];
  logic [31:0] dm_ff [2];
  logic [8:0] cv_ff [2];
  logic [7:0] cm_ff [2];
  logic dis_ff;
  logic debug_abort_flag_ff;
  logic nxt_debug_abort_flag;
  wire [1:0] raw_hit;
  logic [31:0] unit_rd [2];
  wire [`WPBRK_ADDR_W-1:0] ofs;
  wire sel_u1;
  wire sel_dis;

  assign sel_u1 = cfg_addr[3];
  assign sel_dis = (cfg_addr == `WPBRK_OFS_DIS);
  assign ofs = {2'h0, cfg_addr[2:0]};

  genvar g;
  for (g = 0; g < 2; g++) begin : g_unit
    wire wr_u;
    wire [7:0] bus_ctl;
    assign wr_u = cfg_wr & ~sel_dis & ~cfg_addr[4] & (sel_u1 == 1'(g));
    // Select bit fetch 0 / data 1, direction read 0 / write 1
    assign bus_ctl = {2'h0, external_watch_condition[g], privileged_access_select,
                      fetch_or_data_select, bus_size, bus_write};
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        av_ff[g] <= `WPBRK_RST_VAL;
        am_ff[g] <= `WPBRK_RST_MASK;
        dv_ff[g] <= `WPBRK_RST_VAL;
        dm_ff[g] <= `WPBRK_RST_MASK;
        cv_ff[g] <= `WPBRK_RST_CV;
        cm_ff[g] <= `WPBRK_RST_CM;
      end else if (wr_u) begin
        if (ofs == `WPBRK_OFS_AV) av_ff[g] <= cfg_wdata;
        if (ofs == `WPBRK_OFS_AM) am_ff[g] <= cfg_wdata;
        if (ofs == `WPBRK_OFS_DV) dv_ff[g] <= cfg_wdata;
        if (ofs == `WPBRK_OFS_DM) dm_ff[g] <= cfg_wdata;
        if (ofs == `WPBRK_OFS_CV) cv_ff[g] <= cfg_wdata[8:0];
        if (ofs == `WPBRK_OFS_CM) cm_ff[g] <= cfg_wdata[7:0];
      end
    end
    wpbrk_unit u_cmp (
      .addr_val(av_ff[g]),
      .addr_mask(am_ff[g]),
      .data_val(dv_ff[g]),
      .data_mask(dm_ff[g]),
      .ctl_val(cv_ff[g]),
      .ctl_mask(cm_ff[g]),
      .bus_addr(bus_addr),
      .bus_data(bus_data),
      .bus_ctl(bus_ctl),
      .half_fetch(half_fetch),
      .hit(raw_hit[g])
    );
    assign unit_rd[g] = (ofs == `WPBRK_OFS_AV) ? av_ff[g] :
                        (ofs == `WPBRK_OFS_AM) ? am_ff[g] :
                        (ofs == `WPBRK_OFS_DV) ? dv_ff[g] :
                        (ofs == `WPBRK_OFS_DM) ? dm_ff[g] :
                        (ofs == `WPBRK_OFS_CV) ? {23'h0, cv_ff[g]} :
                        (ofs == `WPBRK_OFS_CM) ? {24'h0, cm_ff[g]} : 32'h0000_0000;
  end

  // Disable gate lets the debugger reprogram without spurious hits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dis_ff <= 1'b0;
    end else if (cfg_wr & sel_dis) begin
      dis_ff <= cfg_wdata[0];
    end
  end

  assign unit_hit = (bus_valid & ~dis_ff) ? raw_hit : 2'h0;
  assign debug_break = |unit_hit;

  // External abort blocks the debug-abort set; flag then kept unless a status write loads it
  assign nxt_debug_abort_flag = (debug_abort_taken & ~external_abort) ? 1'b1 :
                                coprocessor_write_instruction ? coprocessor_wdata[`WPBRK_ABT_BIT] :
                                debug_abort_flag_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      debug_abort_flag_ff <= 1'b0;
    end else begin
      debug_abort_flag_ff <= nxt_debug_abort_flag;
    end
  end

  assign coprocessor_rdata = {31'h0000_0000, debug_abort_flag_ff};
  assign cfg_rdata = sel_dis ? {31'h0000_0000, dis_ff} :
                     cfg_addr[4] ? 32'h0000_0000 : unit_rd[sel_u1];

  a_abort_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
    debug_abort_taken && !external_abort |=> debug_abort_flag_ff)
    else $error("debug abort did not set flag");
  a_set_beats_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    debug_abort_taken && !external_abort && coprocessor_write_instruction |=> debug_abort_flag_ff)
    else $error("status write beat a debug abort");
  a_ext_priority: assert property (@(posedge sys_clk) disable iff (!resetn)
    debug_abort_taken && external_abort && !coprocessor_write_instruction
    |=> debug_abort_flag_ff == $past(debug_abort_flag_ff))
    else $error("external abort changed flag");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    debug_abort_flag_ff && !coprocessor_write_instruction |=> debug_abort_flag_ff)
    else $error("flag dropped without write");
  a_upper_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    coprocessor_rdata[31:1] == 31'h0000_0000 && coprocessor_rdata[0] == debug_abort_flag_ff)
    else $error("status upper bits nonzero");
  a_sw_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    coprocessor_write_instruction && !debug_abort_taken
    |=> debug_abort_flag_ff == $past(coprocessor_wdata[0]))
    else $error("status write not taken");
  a_disable_blocks: assert property (@(posedge sys_clk) disable iff (!resetn)
    dis_ff |-> unit_hit == 2'h0)
    else $error("hit while disabled");
  a_enable_needed: assert property (@(posedge sys_clk) disable iff (!resetn)
    unit_hit[0] |-> cv_ff[0][`WPBRK_CTL_ENABLE] && raw_hit[0])
    else $error("hit without enable");
  a_full_mask_hit: assert property (@(posedge sys_clk) disable iff (!resetn)
    bus_valid && !dis_ff && am_ff[0] == 32'hFFFF_FFFF && dm_ff[0] == 32'hFFFF_FFFF
    && cm_ff[0] == 8'hFF && cv_ff[0][`WPBRK_CTL_ENABLE] |-> unit_hit[0])
    else $error("fully masked unit missed");
  a_exact_miss: assert property (@(posedge sys_clk) disable iff (!resetn)
    am_ff[1] == 32'h0000_0000 && bus_addr != av_ff[1] |-> !unit_hit[1])
    else $error("unmasked address mismatch hit");
  // Bus-facing checks, seen from the matching side
  a_range_match: assert property (@(posedge sys_clk) disable iff (!resetn)
    unit_hit[1] |-> ((bus_addr ^ av_ff[1]) & ~am_ff[1]) == 32'h0000_0000)
    else $error("hit outside masked address range");
  a_fetch_select: assert property (@(posedge sys_clk) disable iff (!resetn)
    unit_hit[0] && !cm_ff[0][`WPBRK_CTL_FOD] |-> fetch_or_data_select == cv_ff[0][`WPBRK_CTL_FOD])
    else $error("hit on wrong fetch or data kind");
  a_dir_match: assert property (@(posedge sys_clk) disable iff (!resetn)
    unit_hit[0] && !cm_ff[0][`WPBRK_CTL_WRITE] |-> bus_write == cv_ff[0][`WPBRK_CTL_WRITE])
    else $error("hit on wrong direction");
  a_half_valid: assert property (@(posedge sys_clk) disable iff (!resetn)
    unit_hit[1] && half_fetch && dm_ff[1] == 32'h0000_0000
    |-> (bus_addr[1] ? bus_data[31:16] == dv_ff[1][31:16] : bus_data[15:0] == dv_ff[1][15:0]))
    else $error("halfword compare used wrong half");
endmodule : wpbrk_top

// >>> pkg/wpbrk_regs.svh
// Register offsets, field positions and reset values of the comparator block
`ifndef WPBRK_REGS_SVH
`define WPBRK_REGS_SVH
`define WPBRK_ADDR_W 5
`define WPBRK_OFS_AV 5'h00
`define WPBRK_OFS_AM 5'h01
`define WPBRK_OFS_DV 5'h02
`define WPBRK_OFS_DM 5'h03
`define WPBRK_OFS_CV 5'h04
`define WPBRK_OFS_CM 5'h05
`define WPBRK_UNIT_STRIDE 5'h08
`define WPBRK_OFS_DIS 5'h10
`define WPBRK_CTL_WRITE 0
`define WPBRK_CTL_SIZE_LO 1
`define WPBRK_CTL_SIZE_HI 2
`define WPBRK_CTL_FOD 3
`define WPBRK_CTL_PRIV 4
`define WPBRK_CTL_EXT 5
`define WPBRK_CTL_ENABLE 8
`define WPBRK_RST_VAL 32'h0000_0000
`define WPBRK_RST_MASK 32'hFFFF_FFFF
`define WPBRK_RST_CV 9'h000
`define WPBRK_RST_CM 8'hFF
`define WPBRK_ABT_BIT 0
`endif

// >>> pkg/wpbrk_pkg.sv
// Types shared by the comparator block
package wpbrk_pkg;
  typedef enum logic [1:0] {
    WPBRK_SZ_BYTE = 2'h0,
    WPBRK_SZ_HALF = 2'h1,
    WPBRK_SZ_WORD = 2'h2,
    WPBRK_SZ_RSVD = 2'h3
  } wpbrk_size_t;
endpackage : wpbrk_pkg

// >>> test/wpbrk_dbg_model.sv
// Debugger model that programs the comparator registers
`timescale 1ns/1ps
module wpbrk_dbg_model (
  input wire logic sys_clk,
  output logic cfg_wr,
  output logic [4:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata
);
  logic [31:0] code_word;
  logic [31:0] saved_insn;
  initial begin
    code_word = 32'h4A5B_6C7D;
    saved_insn = 32'h0000_0000;
    cfg_wr = 1'b0;
    cfg_addr = 5'h1F;
    cfg_wdata = 32'h0000_0000;
  end
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge sys_clk);
    #1;
    cfg_wr = 1'b0;
    cfg_wdata = ~d; // Released bus must not keep the old value
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    #1;
    cfg_addr = a;
    #1;
    d = cfg_rdata;
  endtask : rd
  task automatic prog(input logic [4:0] b, input logic [31:0] av, am, dv, dm, input logic [8:0] cv,
      input logic [7:0] cm);
    wr(5'h10, 32'h0000_0001);
    wr(b, av);
    wr(b + 5'h01, am);
    wr(b + 5'h02, dv);
    wr(b + 5'h03, dm);
    wr(b + 5'h04, {23'h0, cv});
    wr(b + 5'h05, {24'h0, cm});
    wr(5'h10, 32'h0000_0000);
  endtask : prog
  task automatic hw_bp(input logic [4:0] b, input logic [31:0] a, input logic half);
    prog(b, a, half ? 32'h0000_0001 : 32'h0000_0003, 32'h0, 32'hFFFF_FFFF, 9'h100, 8'hF7);
  endtask : hw_bp
  task automatic sw_bp(input logic [4:0] b, input logic [15:0] p);
    prog(b, 32'h0, 32'hFFFF_FFFF, {p, p}, 32'h0, 9'h100, 8'hF7);
  endtask : sw_bp
  task automatic watch(input logic [4:0] b, input logic [31:0] a, input logic w, input logic [1:0] sz);
    prog(b, a, 32'h0, 32'h0, 32'hFFFF_FFFF, {6'h21, sz, w}, 8'hF0);
  endtask : watch
  // Target code word; original saved before the pattern goes in
  task automatic plant(input logic [31:0] p);
    saved_insn = code_word;
    code_word = p;
  endtask : plant
  task automatic unplant();
    code_word = saved_insn;
  endtask : unplant
endmodule : wpbrk_dbg_model

// >>> test/wpbrk_tb_top.sv
// Self-checking bench for the comparator block
`timescale 1ns/1ps
module wpbrk_tb_top;
  import wpbrk_pkg::*;
  logic sys_clk, resetn, cfg_wr, bus_valid, bus_write, fetch_or_data_select, half_fetch;
  logic privileged_access_select, debug_abort_taken, external_abort, coprocessor_write_instruction, debug_break;
  logic [4:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, bus_addr, bus_data, coprocessor_wdata, coprocessor_rdata, d;
  logic [1:0] external_watch_condition, unit_hit;
  wpbrk_size_t bus_size;
  int err_count, n_checks, cyc_cnt;
  wpbrk_top i_dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata),
    .bus_addr(bus_addr),
    .bus_data(bus_data),
    .bus_valid(bus_valid),
    .bus_write(bus_write),
    .bus_size(bus_size),
    .fetch_or_data_select(fetch_or_data_select),
    .privileged_access_select(privileged_access_select),
    .external_watch_condition(external_watch_condition),
    .half_fetch(half_fetch),
    .debug_abort_taken(debug_abort_taken),
    .external_abort(external_abort),
    .coprocessor_write_instruction(coprocessor_write_instruction),
    .coprocessor_wdata(coprocessor_wdata),
    .coprocessor_rdata(coprocessor_rdata),
    .unit_hit(unit_hit),
    .debug_break(debug_break)
  );
  wpbrk_dbg_model i_dbg (.sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  // One bus cycle; hit outputs are combinational
  task automatic cyc(input logic [31:0] a, dt, input logic f, w, h, input logic [1:0] e);
    @(posedge sys_clk);
    #1;
    {bus_addr, bus_data, fetch_or_data_select, bus_write, half_fetch, bus_valid} = {a, dt, f, w, h, 1'b1};
    #1;
    chk({unit_hit, debug_break}, {e, |e});
  endtask : cyc
  task automatic abt(input logic t, x, c, input logic [31:0] dw, e);
    @(posedge sys_clk);
    #1;
    {debug_abort_taken, external_abort, coprocessor_write_instruction, coprocessor_wdata} = {t, x, c, dw};
    @(posedge sys_clk);
    #1;
    {debug_abort_taken, external_abort, coprocessor_write_instruction, coprocessor_wdata} = {3'h0, ~dw};
    chk(coprocessor_rdata, e);
  endtask : abt
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    {resetn, bus_valid, bus_write, fetch_or_data_select, half_fetch, privileged_access_select} = 6'h0;
    {debug_abort_taken, external_abort, coprocessor_write_instruction, external_watch_condition} = 5'h0;
    {bus_addr, bus_data, coprocessor_wdata} = 96'h0;
    bus_size = WPBRK_SZ_WORD;
    repeat (16) @(posedge sys_clk);
    #1 resetn = 1'b1;
    chk(coprocessor_rdata, 32'h0);
    cyc(32'h0000_0100, 32'h0, 1'b0, 1'b0, 1'b0, 2'b00);
    i_dbg.hw_bp(5'h00, 32'h0000_0100, 1'b0);
    cyc(32'h0000_0103, 32'h0, 1'b0, 1'b0, 1'b0, 2'b01);
    cyc(32'h0000_0104, 32'h0, 1'b0, 1'b0, 1'b0, 2'b00);
    cyc(32'h0000_0100, 32'h0, 1'b1, 1'b0, 1'b0, 2'b00);
    i_dbg.hw_bp(5'h08, 32'h0000_0200, 1'b1);
    cyc(32'h0000_0201, 32'h0, 1'b0, 1'b0, 1'b1, 2'b10);
    cyc(32'h0000_0202, 32'h0, 1'b0, 1'b0, 1'b1, 2'b00);
    i_dbg.wr(5'h10, 32'h0000_0001);
    cyc(32'h0000_0100, 32'h0, 1'b0, 1'b0, 1'b0, 2'b00);
    i_dbg.sw_bp(5'h08, 16'hDFFF);
    i_dbg.plant(32'h1234_DFFF);
    cyc(32'h0000_3000, i_dbg.code_word, 1'b0, 1'b0, 1'b1, 2'b10);
    cyc(32'h0000_3002, 32'h1234_DFFF, 1'b0, 1'b0, 1'b1, 2'b00);
    cyc(32'h0000_3002, 32'hDFFF_1234, 1'b0, 1'b0, 1'b1, 2'b10);
    cyc(32'h0000_3000, 32'h1234_DFFF, 1'b0, 1'b0, 1'b0, 2'b00);
    i_dbg.unplant();
    chk(i_dbg.code_word, 32'h4A5B_6C7D);
    cyc(32'h0000_3000, i_dbg.code_word, 1'b0, 1'b0, 1'b1, 2'b00);
    i_dbg.watch(5'h00, 32'h0000_0400, 1'b1, WPBRK_SZ_WORD);
    cyc(32'h0000_0400, 32'h5A5A_0F0F, 1'b1, 1'b1, 1'b0, 2'b01);
    cyc(32'h0000_0400, 32'h5A5A_0F0F, 1'b1, 1'b0, 1'b0, 2'b00);
    @(posedge sys_clk);
    #1 bus_size = WPBRK_SZ_HALF;
    cyc(32'h0000_0400, 32'h5A5A_0F0F, 1'b1, 1'b1, 1'b0, 2'b00);
    i_dbg.rd(5'h00, d);
    chk(d, 32'h0000_0400);
    i_dbg.rd(5'h1F, d);
    chk(d, 32'h0);
    abt(1'b1, 1'b1, 1'b0, 32'h0, 32'h0);
    abt(1'b1, 1'b0, 1'b0, 32'h0, 32'h1);
    abt(1'b0, 1'b0, 1'b0, 32'h0, 32'h1);
    abt(1'b0, 1'b0, 1'b1, 32'hFFFF_FFFF, 32'h1);
    abt(1'b0, 1'b0, 1'b1, 32'h0, 32'h0);
    abt(1'b1, 1'b0, 1'b1, 32'h0, 32'h1);
    give_verdict();
  end
endmodule : wpbrk_tb_top
